// ### src/wdr_pkg.sv
package wdr_pkg;

	// Register map
	localparam logic [7:0] WDR_ADDR_HIT_CONTROL = 8'h08;
	localparam logic [7:0] WDR_ADDR_TEST_CONTROL = 8'h09;
	localparam logic [7:0] WDR_ADDR_STATUS = 8'h0a;
	localparam logic [7:0] WDR_ADDR_COUNT_LOW = 8'h0b;
	localparam logic [7:0] WDR_ADDR_COUNT_HIGH = 8'h0c;
	localparam logic [7:0] WDR_ADDR_GLOBAL_OUTPUT_CONTROL = 8'h0e;

	// Hit codes
	localparam logic [7:0] WDR_HIT_2S = 8'h5a;
	localparam logic [7:0] WDR_HIT_1S = 8'h57;
	localparam logic [7:0] WDR_HIT_500MS = 8'h59;
	localparam logic [7:0] WDR_HIT_250MS = 8'h53;

	// Test codes
	localparam logic [7:0] WDR_TEST_LOW = 8'h51;
	localparam logic [7:0] WDR_TEST_HIGH = 8'h52;
	localparam logic [7:0] WDR_TEST_BOTH = 8'h53;
	localparam logic [7:0] WDR_TEST_DISABLE = 8'h54;

	// Field positions and reset values
	localparam int WDR_GOC_PIN_LOW_BIT = 3;
	localparam logic [7:0] WDR_GOC_RESET = 8'h00;
	localparam int WDR_COUNT_WIDTH = 17;
	localparam int WDR_LOW_WIDTH = 8;

	// Timeout periods in ms, counted in 32 kHz oscillator ticks
	localparam int WDR_OSC_HZ = 32768;
	localparam int WDR_PERIOD_2S_MS = 2000;
	localparam int WDR_PERIOD_1S_MS = 1000;
	localparam int WDR_PERIOD_500MS_MS = 500;
	localparam int WDR_PERIOD_250MS_MS = 250;
	localparam logic [16:0] WDR_COUNT_2S = 17'(WDR_PERIOD_2S_MS * WDR_OSC_HZ / 1000);
	localparam logic [16:0] WDR_COUNT_1S = 17'(WDR_PERIOD_1S_MS * WDR_OSC_HZ / 1000);
	localparam logic [16:0] WDR_COUNT_500MS = 17'(WDR_PERIOD_500MS_MS * WDR_OSC_HZ / 1000);
	localparam logic [16:0] WDR_COUNT_250MS = 17'(WDR_PERIOD_250MS_MS * WDR_OSC_HZ / 1000);

	// Reset sequence, counted in fast oscillator (ref_clk) cycles
	localparam int WDR_RESET_MIN_CYCLES = 128;

	// Boot memory defaults: 4 wait states, fetch of 8 x (2 + 4) clocks
	localparam logic [3:0] WDR_BOOT_WAIT_STATES = 4'h4;
	localparam int WDR_BOOT_FETCH_CYCLES = 8 * (2 + 4);

	typedef enum logic [1:0] {
		WDR_CLK_NORMAL,
		WDR_CLK_LOW_PERIPH,
		WDR_CLK_HIGH_PERIPH,
		WDR_CLK_BOTH_PERIPH
	} wdr_clk_mode_t;

	typedef enum logic [1:0] {
		WDR_SEQ_IDLE,
		WDR_SEQ_WAIT_WRITE,
		WDR_SEQ_HOLD
	} wdr_seq_state_t;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} wdr_reg_req_t;

	// Active-high requests from the core for memory bank zero
	typedef struct packed {
		logic cs;
		logic oe;
		logic we;
	} wdr_mem_ctl_t;

	typedef struct packed {
		logic [3:0] wait_states;
		logic [1:0] cs_select;
		logic [1:0] oe_select;
		logic [1:0] we_select;
		logic write_enable;
	} wdr_boot_cfg_t;

endpackage : wdr_pkg

// ### src/wdr_reset_seq.sv
`timescale 1ns/1ps

module wdr_reset_seq import wdr_pkg::*; (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic reset_n,
	// Reset sources
	input wire logic master_reset_n,
	input wire logic wdt_timeout,
	// Memory write in progress
	input wire logic write_busy,
	// Sequence state
	output logic seq_hold,
	output logic core_reset_n
);

	localparam int CW = $clog2(WDR_RESET_MIN_CYCLES);

	wdr_seq_state_t state;
	wdr_seq_state_t next_state;
	logic [CW-1:0] hold_cnt;
	logic [CW-1:0] next_hold_cnt;

	wire request = !master_reset_n || wdt_timeout;
	wire hold_done = (hold_cnt == CW'(WDR_RESET_MIN_CYCLES - 1)) && master_reset_n;

	always_comb begin
		next_state = state;
		next_hold_cnt = hold_cnt;
		unique case (state)
			WDR_SEQ_IDLE: begin
				next_hold_cnt = '0;
				if (request) begin
					next_state = write_busy ? WDR_SEQ_WAIT_WRITE : WDR_SEQ_HOLD;
				end
			end
			WDR_SEQ_WAIT_WRITE: begin
				if (!write_busy) begin
					next_state = WDR_SEQ_HOLD;
				end
			end
			WDR_SEQ_HOLD: begin
				// Counter saturates while the pin is still held low
				if (hold_done) begin
					next_state = WDR_SEQ_IDLE;
				end else if (hold_cnt != CW'(WDR_RESET_MIN_CYCLES - 1)) begin
					next_hold_cnt = hold_cnt + CW'(1);
				end
			end
			default: next_state = WDR_SEQ_HOLD;
		endcase
	end

	// Power-up starts inside a full sequence
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			state <= WDR_SEQ_HOLD;
			hold_cnt <= '0;
		end else begin
			state <= next_state;
			hold_cnt <= next_hold_cnt;
		end
	end

	assign seq_hold = (state == WDR_SEQ_HOLD);
	assign core_reset_n = !seq_hold;

endmodule : wdr_reset_seq

// ### src/wdr_watchdog.sv
`timescale 1ns/1ps

module wdr_watchdog import wdr_pkg::*; #(
	parameter int COUNT_WIDTH = WDR_COUNT_WIDTH,
	parameter int LOW_WIDTH = WDR_LOW_WIDTH
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic reset_n,
	// Master reset pin and memory write activity
	input wire logic master_reset_n,
	input wire logic write_busy,
	// Time bases, one-cycle enables
	input wire logic osc32_tick,
	input wire logic periph_tick,
	// Register port
	input wire wdr_reg_req_t reg_req,
	output logic [7:0] reg_rdata,
	// Watchdog pin
	output logic watchdog_pulse_out_n,
	// Processor reset and clock forcing
	output logic core_reset_n,
	output logic cpu_clk_div8,
	output logic periph_clk_div8,
	// Memory control from core and to pins
	input wire wdr_mem_ctl_t mem_req,
	output logic memory_chip_select_zero_n,
	output logic memory_output_enable_zero_n,
	output logic memory_write_enable_zero_n,
	output wdr_boot_cfg_t boot_cfg
);

	localparam int HIGH_WIDTH = COUNT_WIDTH - LOW_WIDTH;

	// Sequencer
	logic seq_hold;
	logic seq_core_reset_n;

	// Watchdog state
	logic [LOW_WIDTH-1:0] count_low;
	logic [HIGH_WIDTH-1:0] count_high;
	logic [COUNT_WIDTH-1:0] period;
	wdr_clk_mode_t clk_mode;
	logic disabled;
	logic armed_for_disable;
	logic timeout_pulse;
	logic [7:0] global_output_control;
	logic [7:0] next_rdata;

	// Register decode
	wire wr_hit = reg_req.wr && (reg_req.addr == WDR_ADDR_HIT_CONTROL);
	wire wr_test = reg_req.wr && (reg_req.addr == WDR_ADDR_TEST_CONTROL);
	wire wr_goc = reg_req.wr && (reg_req.addr == WDR_ADDR_GLOBAL_OUTPUT_CONTROL);
	wire [7:0] wdata = reg_req.wdata;

	// Hit code to period
	wire hit_2s = (wdata == WDR_HIT_2S);
	wire hit_1s = (wdata == WDR_HIT_1S);
	wire hit_500 = (wdata == WDR_HIT_500MS);
	wire hit_250 = (wdata == WDR_HIT_250MS);
	wire hit_valid = wr_hit && (hit_2s || hit_1s || hit_500 || hit_250);
	wire [COUNT_WIDTH-1:0] hit_period =
		hit_2s ? COUNT_WIDTH'(WDR_COUNT_2S) :
		hit_1s ? COUNT_WIDTH'(WDR_COUNT_1S) :
		hit_500 ? COUNT_WIDTH'(WDR_COUNT_500MS) :
		COUNT_WIDTH'(WDR_COUNT_250MS);

	// Test code decode
	wire test_low = (wdata == WDR_TEST_LOW);
	wire test_high = (wdata == WDR_TEST_HIGH);
	wire test_both = (wdata == WDR_TEST_BOTH);
	wire test_clk_code = test_low || test_high || test_both;
	wire test_disable = (wdata == WDR_TEST_DISABLE);
	wire [1:0] test_mode_sel = {test_high || test_both, test_low || test_both};

	// Lone disable code only re-enables, like any other write
	wire next_disabled = test_disable && armed_for_disable;

	// Counter stepping per clocking mode
	wire normal_mode = (clk_mode == WDR_CLK_NORMAL);
	wire low_periph = (clk_mode == WDR_CLK_LOW_PERIPH) || (clk_mode == WDR_CLK_BOTH_PERIPH);
	wire high_periph = (clk_mode == WDR_CLK_HIGH_PERIPH) || (clk_mode == WDR_CLK_BOTH_PERIPH);
	wire step_full = normal_mode && osc32_tick;
	wire step_low = low_periph && periph_tick;
	wire step_high = high_periph && periph_tick;
	wire [COUNT_WIDTH-1:0] count = {count_high, count_low};
	wire [COUNT_WIDTH-1:0] count_inc = count + COUNT_WIDTH'(1);

	// Timeout when the count reaches the latched period
	wire reached = (count == period);
	wire timeout = reached && !disabled && !seq_hold && !timeout_pulse;

	// Status readback
	wire [7:0] status_word = {3'h0, timeout_pulse, armed_for_disable, disabled, clk_mode};

	assign next_rdata =
		!reg_req.rd ? 8'h00 :
		(reg_req.addr == WDR_ADDR_STATUS) ? status_word :
		(reg_req.addr == WDR_ADDR_COUNT_LOW) ? count[7:0] :
		(reg_req.addr == WDR_ADDR_COUNT_HIGH) ? {7'h00, count[COUNT_WIDTH-1]} :
		(reg_req.addr == WDR_ADDR_GLOBAL_OUTPUT_CONTROL) ? global_output_control :
		8'h00;

	wdr_reset_seq u_reset_seq (
		.ref_clk(ref_clk),
		.reset_n(reset_n),
		.master_reset_n(master_reset_n),
		.wdt_timeout(timeout),
		.write_busy(write_busy),
		.seq_hold(seq_hold),
		.core_reset_n(seq_core_reset_n)
	);

	// Low byte of the counter
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			count_low <= '0;
		end else if (seq_hold || hit_valid) begin
			count_low <= '0;
		end else if (step_full) begin
			count_low <= count_inc[LOW_WIDTH-1:0];
		end else if (step_low) begin
			count_low <= count_low + LOW_WIDTH'(1);
		end
	end

	// High part; in test modes the low byte and the 9-bit high part count separately, each only when its mode bit selects it
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			count_high <= '0;
		end else if (seq_hold || hit_valid) begin
			count_high <= '0;
		end else if (step_full) begin
			count_high <= count_inc[COUNT_WIDTH-1:LOW_WIDTH];
		end else if (step_high) begin
			count_high <= count_high + HIGH_WIDTH'(1);
		end
	end

	// Period latched by a valid hit; 2 s until the first hit
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			period <= COUNT_WIDTH'(WDR_COUNT_2S);
		end else if (seq_hold) begin
			period <= COUNT_WIDTH'(WDR_COUNT_2S);
		end else if (hit_valid) begin
			period <= hit_period;
		end
	end

	// Clocking mode from the test register
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			clk_mode <= WDR_CLK_NORMAL;
		end else if (seq_hold) begin
			clk_mode <= WDR_CLK_NORMAL;
		end else if (wr_test) begin
			clk_mode <= wdr_clk_mode_t'(test_mode_sel);
		end
	end

	// Disable sequence tracking
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			disabled <= 1'b0;
			armed_for_disable <= 1'b0;
		end else if (seq_hold) begin
			disabled <= 1'b0;
			armed_for_disable <= 1'b0;
		end else if (wr_test) begin
			disabled <= next_disabled;
			armed_for_disable <= test_clk_code;
		end
	end

	// Pulse spans one 32 kHz period, ended by the next tick
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			timeout_pulse <= 1'b0;
		end else if (timeout) begin
			timeout_pulse <= 1'b1;
		end else if (osc32_tick) begin
			timeout_pulse <= 1'b0;
		end
	end

	// Global output control; only the watchdog pin bit acts here
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			global_output_control <= WDR_GOC_RESET;
		end else if (seq_hold) begin
			global_output_control <= WDR_GOC_RESET;
		end else if (wr_goc) begin
			global_output_control <= {4'h0, wdata[WDR_GOC_PIN_LOW_BIT], 3'h0};
		end
	end

	// Read data, valid only in the cycle after the strobe
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			reg_rdata <= 8'h00;
		end else begin
			reg_rdata <= next_rdata;
		end
	end

	// Watchdog pin, registered
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			watchdog_pulse_out_n <= 1'b1;
		end else if (global_output_control[WDR_GOC_PIN_LOW_BIT]) begin
			watchdog_pulse_out_n <= 1'b0;
		end else begin
			watchdog_pulse_out_n <= !(timeout || timeout_pulse);
		end
	end

	// Processor reset and clock forcing
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			core_reset_n <= 1'b0;
			cpu_clk_div8 <= 1'b1;
			periph_clk_div8 <= 1'b1;
		end else begin
			core_reset_n <= seq_core_reset_n;
			cpu_clk_div8 <= seq_hold;
			periph_clk_div8 <= seq_hold;
		end
	end

	// Memory pins held inactive through the sequence
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			memory_chip_select_zero_n <= 1'b1;
			memory_output_enable_zero_n <= 1'b1;
			memory_write_enable_zero_n <= 1'b1;
		end else if (seq_hold) begin
			memory_chip_select_zero_n <= 1'b1;
			memory_output_enable_zero_n <= 1'b1;
			memory_write_enable_zero_n <= 1'b1;
		end else begin
			memory_chip_select_zero_n <= !mem_req.cs;
			memory_output_enable_zero_n <= !mem_req.oe;
			memory_write_enable_zero_n <= !(mem_req.we && boot_cfg.write_enable);
		end
	end

	// Boot bank defaults; reloaded by every sequence and otherwise held unchanged
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			boot_cfg <= '{wait_states: WDR_BOOT_WAIT_STATES, cs_select: 2'h0,
				oe_select: 2'h0, we_select: 2'h0, write_enable: 1'b1};
		end else if (seq_hold) begin
			boot_cfg <= '{wait_states: WDR_BOOT_WAIT_STATES, cs_select: 2'h0,
				oe_select: 2'h0, we_select: 2'h0, write_enable: 1'b1};
		end
	end

endmodule : wdr_watchdog

// ### tb/wdr_watchdog_sva.sv
`timescale 1ns/1ps

module wdr_watchdog_sva import wdr_pkg::*; #(
	parameter int COUNT_WIDTH = WDR_COUNT_WIDTH,
	parameter int LOW_WIDTH = WDR_LOW_WIDTH
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic reset_n,
	// Inputs
	input wire logic write_busy,
	input wire wdr_reg_req_t reg_req,
	input wire wdr_mem_ctl_t mem_req,
	// Outputs
	input wire logic watchdog_pulse_out_n,
	input wire logic core_reset_n,
	input wire logic cpu_clk_div8,
	input wire logic periph_clk_div8,
	input wire logic memory_chip_select_zero_n,
	input wire logic memory_output_enable_zero_n,
	input wire logic memory_write_enable_zero_n,
	input wire wdr_boot_cfg_t boot_cfg
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!reset_n);

	logic goc_q;
	logic [7:0] low_cnt;
	wire goc_wr = reg_req.wr && reg_req.addr == WDR_ADDR_GLOBAL_OUTPUT_CONTROL;

	// Shadow of the pin-force bit, dropped whenever the core is held
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			goc_q <= 1'b0;
		end else if (!core_reset_n) begin
			goc_q <= 1'b0;
		end else if (goc_wr) begin
			goc_q <= reg_req.wdata[3];
		end
	end

	// Saturates so a long master reset cannot wrap into a false short hold
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			low_cnt <= 8'h00;
		end else if (core_reset_n) begin
			low_cnt <= 8'h00;
		end else if (low_cnt != 8'hff) begin
			low_cnt <= low_cnt + 8'h01;
		end
	end

	a_mem_idle_rst: assert property (!core_reset_n |-> memory_chip_select_zero_n &&
		memory_output_enable_zero_n && memory_write_enable_zero_n)
		else $error("memory control active while core held");
	a_mem_follow: assert property (core_reset_n && $past(core_reset_n) |->
		memory_chip_select_zero_n == !$past(mem_req.cs) &&
		memory_write_enable_zero_n == !$past(mem_req.we))
		else $error("memory control does not follow core request");
	a_div8_rst: assert property (!core_reset_n && !$past(core_reset_n) |->
		cpu_clk_div8 && periph_clk_div8)
		else $error("clocks not forced to divide by eight");
	a_min_hold: assert property ($rose(core_reset_n) |-> low_cnt >= 8'h80)
		else $error("reset sequence shorter than minimum");
	a_defer_busy: assert property (write_busy && core_reset_n |=> core_reset_n)
		else $error("reset taken during memory write");
	// Core reset is registered one edge behind the pin
	a_timeout_rst: assert property ($fell(watchdog_pulse_out_n) && !goc_q &&
		!$past(write_busy) |-> ##1 !core_reset_n)
		else $error("watchdog pulse without processor reset");
	a_pin_force: assert property (goc_q && $past(goc_q) |-> !watchdog_pulse_out_n)
		else $error("pin not forced low");
	a_boot_dflt: assert property (boot_cfg == {WDR_BOOT_WAIT_STATES, 7'h01})
		else $error("boot memory defaults wrong");
endmodule : wdr_watchdog_sva

// ### tb/tb_watchdog_and_reset_sequencer.sv
`timescale 1ns/1ps

module tb_watchdog_and_reset_sequencer import wdr_pkg::*; ;
	typedef struct {logic [7:0] code; int lim; bit to;} wdr_row_t;
	logic ref_clk, reset_n, master_reset_n, write_busy, osc32_tick, periph_tick;
	wdr_reg_req_t reg_req;
	wdr_mem_ctl_t mem_req;
	logic [7:0] reg_rdata, d;
	logic watchdog_pulse_out_n, core_reset_n, cpu_clk_div8, periph_clk_div8;
	logic memory_chip_select_zero_n, memory_output_enable_zero_n, memory_write_enable_zero_n;
	wdr_boot_cfg_t boot_cfg;
	int fails, compares, n;
	// Non-timeout rows probe just past the next shorter period
	wdr_row_t rows[4] = '{'{8'h53, 8192, 1}, '{8'h59, 16384, 1},
		'{8'h57, 16390, 0}, '{8'h5a, 32780, 0}};

	wdr_watchdog dut (.ref_clk, .reset_n, .master_reset_n, .write_busy, .osc32_tick,
		.periph_tick, .reg_req, .reg_rdata, .watchdog_pulse_out_n, .core_reset_n,
		.cpu_clk_div8, .periph_clk_div8, .mem_req, .memory_chip_select_zero_n,
		.memory_output_enable_zero_n, .memory_write_enable_zero_n, .boot_cfg);

	initial begin
		ref_clk = 1'b0;
		forever #4 ref_clk = ~ref_clk;
	end

	task chk(input string nm, input logic [16:0] s, input logic [16:0] e);
		compares++;
		if (s !== e) begin
			fails++;
			$display("ERROR %s expected %h seen %h", nm, e, s);
		end
	endtask : chk

	task cyc(input int k);
		repeat (k) @(posedge ref_clk);
	endtask : cyc

	task wr(input logic [7:0] a, input logic [7:0] v);
		reg_req.addr <= a;
		reg_req.wdata <= v;
		reg_req.wr <= 1'b1;
		@(posedge ref_clk);
		reg_req.wr <= 1'b0;
		#1;
	endtask : wr

	task rd(input logic [7:0] a, output logic [7:0] v);
		reg_req.addr <= a;
		reg_req.rd <= 1'b1;
		@(posedge ref_clk);
		reg_req.rd <= 1'b0;
		#1 v = reg_rdata;
	endtask : rd

	task wait_core(input logic lvl, input int lim);
		n = 0;
		while (core_reset_n !== lvl && n < lim) begin
			@(posedge ref_clk);
			#1 n++;
		end
	endtask : wait_core

	task to_chk(input int lim, input bit to);
		cyc(lim - 2);
		#1 chk("pin", watchdog_pulse_out_n, 1);
		chk("core", core_reset_n, 1);
		if (to) begin
			n = 0;
			while (watchdog_pulse_out_n !== 1'b0 && n < 8) begin
				@(posedge ref_clk);
				#1 n++;
			end
			chk("pulse", watchdog_pulse_out_n, 0);
			// Core reset follows the pin by one edge
			wait_core(1'b0, 8);
			chk("rst", core_reset_n, 0);
			wait_core(1'b1, 400);
			chk("reboot", core_reset_n, 1);
		end
	endtask : to_chk

	task end_sim;
		$display("compares=%0d fails=%0d", compares, fails);
		if (fails == 0 && compares > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : end_sim

	initial begin
		// About 91k cycles of tests; stays under 100k cycles
		#790000;
		fails++;
		end_sim();
	end

	initial begin
		{reset_n, master_reset_n, write_busy, osc32_tick, periph_tick} = 5'b01010;
		reg_req = '0;
		mem_req = '0;
		fails = 0;
		compares = 0;
		cyc(3);
		reset_n <= 1'b1;
		#1 chk("div8", {cpu_clk_div8, periph_clk_div8}, 2'b11);
		chk("boot", boot_cfg, {WDR_BOOT_WAIT_STATES, 7'h01});
		chk("cs", memory_chip_select_zero_n, 1);
		wait_core(1'b1, 300);
		chk("hold", n >= 128, 1);
		rd(WDR_ADDR_STATUS, d);
		chk("mode", d[2:0], 0);
		foreach (rows[i]) begin
			wr(WDR_ADDR_HIT_CONTROL, rows[i].code);
			to_chk(rows[i].lim, rows[i].to);
		end
		// A stray code mid-period must not restart the count
		wr(WDR_ADDR_HIT_CONTROL, 8'h53);
		cyc(4000);
		wr(WDR_ADDR_HIT_CONTROL, 8'h42);
		to_chk(4191, 1);
		osc32_tick <= 1'b0;
		for (int i = 1; i < 4; i++) begin
			wr(WDR_ADDR_TEST_CONTROL, 8'h50 + 8'(i));
			wr(WDR_ADDR_HIT_CONTROL, WDR_HIT_2S);
			rd(WDR_ADDR_STATUS, d);
			chk("tmode", d[1:0], 17'(i));
			periph_tick <= 1'b1;
			cyc(10);
			periph_tick <= 1'b0;
			rd(WDR_ADDR_COUNT_LOW, d);
			chk("low", d, (i == 2) ? 0 : 10);
			rd(WDR_ADDR_COUNT_HIGH, d);
			chk("high", d, 0);
		end
		wr(WDR_ADDR_TEST_CONTROL, 8'h00);
		wr(WDR_ADDR_TEST_CONTROL, WDR_TEST_DISABLE);
		rd(WDR_ADDR_STATUS, d);
		chk("lone", d[2], 0);
		wr(WDR_ADDR_TEST_CONTROL, WDR_TEST_HIGH);
		wr(WDR_ADDR_TEST_CONTROL, WDR_TEST_DISABLE);
		rd(WDR_ADDR_STATUS, d);
		chk("dis", d[2:0], 3'h4);
		osc32_tick <= 1'b1;
		wr(WDR_ADDR_HIT_CONTROL, WDR_HIT_250MS);
		cyc(8300);
		#1 chk("nodog", core_reset_n, 1);
		wr(WDR_ADDR_TEST_CONTROL, 8'h00);
		wr(WDR_ADDR_HIT_CONTROL, WDR_HIT_2S);
		rd(WDR_ADDR_STATUS, d);
		chk("reen", d[2], 0);
		rd(8'h33, d);
		chk("unmap", d, 0);
		wr(WDR_ADDR_GLOBAL_OUTPUT_CONTROL, 8'h08);
		cyc(2);
		#1 chk("force", watchdog_pulse_out_n, 0);
		wr(WDR_ADDR_GLOBAL_OUTPUT_CONTROL, 8'h00);
		cyc(2);
		#1 chk("free", watchdog_pulse_out_n, 1);
		mem_req <= '{1'b1, 1'b0, 1'b1};
		wr(WDR_ADDR_TEST_CONTROL, WDR_TEST_LOW);
		cyc(2);
		#1 chk("mem", {memory_chip_select_zero_n, memory_output_enable_zero_n,
			memory_write_enable_zero_n}, 3'b010);
		// Master reset arrives in the middle of a memory write
		write_busy <= 1'b1;
		cyc(1);
		master_reset_n <= 1'b0;
		cyc(20);
		#1 chk("defer", core_reset_n, 1);
		write_busy <= 1'b0;
		cyc(3);
		master_reset_n <= 1'b1;
		#1 chk("idle", {memory_chip_select_zero_n, memory_output_enable_zero_n,
			memory_write_enable_zero_n, cpu_clk_div8}, 4'hf);
		wait_core(1'b1, 400);
		chk("hold2", n >= 124, 1);
		rd(WDR_ADDR_STATUS, d);
		chk("clr", d[2:0], 0);
		end_sim();
	end
endmodule : tb_watchdog_and_reset_sequencer

bind wdr_watchdog wdr_watchdog_sva #(.COUNT_WIDTH(COUNT_WIDTH), .LOW_WIDTH(LOW_WIDTH)) u_sva (
	.ref_clk(ref_clk), .reset_n(reset_n), .write_busy(write_busy), .reg_req(reg_req),
	.mem_req(mem_req), .watchdog_pulse_out_n(watchdog_pulse_out_n),
	.core_reset_n(core_reset_n), .cpu_clk_div8(cpu_clk_div8),
	.periph_clk_div8(periph_clk_div8), .memory_chip_select_zero_n(memory_chip_select_zero_n),
	.memory_output_enable_zero_n(memory_output_enable_zero_n),
	.memory_write_enable_zero_n(memory_write_enable_zero_n), .boot_cfg(boot_cfg));
